// ===== rtl/nac_map.svh
// Offsets, field positions, key and response values and timing for the access control block
//
// Summary of operation
// - Program and config selects both low route to data EEPROM
// - Config select high routes to configuration space
// - Writes need write permit; cleared at power-up
// - Write start sets fault; completion clears it
// - Fault stays set after warm reset-cut or improper write
// - Software sets write start; only hardware clears
// - Write completion raises done flag; software clears
// - Read and write start bits cleared on completion
// - Read start refused while program memory selected
// - Unlock port stores nothing, reads zero
// - One control/unlock pair serves all spaces
// - Data byte register plus low/high address pair
// - EEPROM byte write erases location first
// - Two high address bits give 1024 bytes
`ifndef NAC_MAP_SVH
`define NAC_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define NAC_OFF_CTRL     8'h00
`define NAC_OFF_UNLOCK   8'h04
`define NAC_OFF_DATA     8'h08
`define NAC_OFF_ADDR_LO  8'h0C
`define NAC_OFF_ADDR_HI  8'h10
`define NAC_OFF_IRQ_STAT 8'h14
`define NAC_OFF_IRQ_CLR  8'h18
`define NAC_OFF_IRQ_EN   8'h1C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define NAC_CTL_RD     0
`define NAC_CTL_WR     1
`define NAC_CTL_PERMIT 2
`define NAC_CTL_FAULT  3
`define NAC_CTL_ERASE  4
`define NAC_CTL_CFG    6
`define NAC_CTL_PGM    7

// ----------------------------------------
// Values and timing
// ----------------------------------------
`define NAC_UNLOCK_KEY1  8'h55
`define NAC_UNLOCK_KEY2  8'hAA
`define NAC_ERASED_BYTE  8'hFF
`define NAC_RESP_OKAY    2'h0
`define NAC_RESP_SLVERR  2'h2
`define NAC_EE_DEPTH     1024
`define NAC_WRITE_TIME_NS 2000000
`define NAC_CLK_PERIOD_NS 8

`endif

// ===== rtl/nac_pkg.sv
// Types shared by the access control block
package nac_pkg;

    // Memory space that an operation targets
    typedef enum logic [1:0] {
        NAC_SPACE_EE  = 2'b00,
        NAC_SPACE_PGM = 2'b01,
        NAC_SPACE_CFG = 2'b10
    } nac_space_type;

    // Progress of the unlock sequence
    typedef enum logic [1:0] {
        NAC_LOCKED = 2'b00,
        NAC_HALF   = 2'b01,
        NAC_ARMED  = 2'b10
    } nac_unlock_type;

    // Timed operation in progress
    typedef enum logic {
        NAC_OP_IDLE  = 1'b0,
        NAC_OP_WRITE = 1'b1
    } nac_op_type;

    // Write or erase handed to program or configuration storage
    typedef struct packed {
        logic          pulse;
        logic          erase;
        nac_space_type space;
        logic [9:0]    addr;
        logic [7:0]    data;
    } nac_ext_req_type;

endpackage

// ===== rtl/nac_access_control.sv
// Nonvolatile memory access control with AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "nac_map.svh"

module nac_access_control #(
    parameter int unsigned WRITE_CYCLES = `NAC_WRITE_TIME_NS / `NAC_CLK_PERIOD_NS,
    parameter int unsigned EE_DEPTH     = `NAC_EE_DEPTH
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     cold_start,
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    output nac_pkg::nac_ext_req_type      ext_req,
    output logic                          irq
);

    // ----------------------------------------
    // Local types and helpers
    // ----------------------------------------
    localparam int unsigned IDX_W = $clog2(EE_DEPTH);

    // Whole block state; the array keeps its contents over reset
    typedef struct packed {
        logic [EE_DEPTH-1:0][7:0]    mem;       // Data EEPROM cells
        logic                        aw_got;    // Write address held
        logic [7:0]                  aw_addr;   // Held write address
        logic                        w_got;     // Write data held
        logic [7:0]                  w_data;    // Held low data byte
        logic                        w_lane0;   // Low byte lane enabled
        logic                        bvalid;    // Write response pending
        logic [1:0]                  bresp;     // Write response code
        logic                        rvalid;    // Read data pending
        logic [7:0]                  rdata;     // Read data byte
        logic [1:0]                  rresp;     // Read response code
        logic                        rd_start;  // Read start bit
        logic                        wr_start;  // Write start bit
        logic                        permit;    // Write permit bit
        logic                        fault;     // Write fault flag
        logic                        erase_sel; // Erase instead of write
        logic                        cfg_sel;   // Config space select
        logic                        pgm_sel;   // Program space select
        logic [7:0]                  data;      // Data byte register
        logic [7:0]                  addr_lo;   // Address low byte
        logic [1:0]                  addr_hi;   // Address high bits
        nac_pkg::nac_unlock_type     unlock;    // Unlock progress
        nac_pkg::nac_op_type         op;        // Timed operation
        nac_pkg::nac_space_type      space;     // Space of the operation
        logic [31:0]                 count;     // Programming timer
        logic [9:0]                  op_addr;   // Captured address
        logic [7:0]                  op_data;   // Captured data
        logic                        op_erase;  // Captured erase choice
        logic                        done_stat; // Done status, sticky
        logic                        done_en;   // Done interrupt enable
        nac_pkg::nac_ext_req_type    ext;       // Outgoing request
    } nac_state_type;

    nac_state_type state_r;   // Registered state
    nac_state_type state_nxt; // Next state

    // Offsets that answer OKAY; others get SLVERR
    function automatic logic is_mapped(input logic [7:0] a);
        unique case (a)
            `NAC_OFF_CTRL, `NAC_OFF_UNLOCK, `NAC_OFF_DATA,
            `NAC_OFF_ADDR_LO, `NAC_OFF_ADDR_HI, `NAC_OFF_IRQ_STAT,
            `NAC_OFF_IRQ_CLR, `NAC_OFF_IRQ_EN: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // Space chosen by the two select bits; config wins
    function automatic nac_pkg::nac_space_type pick_space(input logic cfg, input logic pgm);
        if (cfg) begin
            pick_space = nac_pkg::NAC_SPACE_CFG;
        end else if (pgm) begin
            pick_space = nac_pkg::NAC_SPACE_PGM;
        end else begin
            pick_space = nac_pkg::NAC_SPACE_EE;
        end
    endfunction

    // Control register image as software reads it
    function automatic logic [7:0] ctrl_image(input nac_state_type s);
        ctrl_image                  = 8'h00;
        ctrl_image[`NAC_CTL_RD]     = s.rd_start;
        ctrl_image[`NAC_CTL_WR]     = s.wr_start;
        ctrl_image[`NAC_CTL_PERMIT] = s.permit;
        ctrl_image[`NAC_CTL_FAULT]  = s.fault;
        ctrl_image[`NAC_CTL_ERASE]  = s.erase_sel;
        ctrl_image[`NAC_CTL_CFG]    = s.cfg_sel;
        ctrl_image[`NAC_CTL_PGM]    = s.pgm_sel;
    endfunction

    // ----------------------------------------
    // Handshake outputs
    // ----------------------------------------
    // Each channel accepts again once its held item is used
    assign s_axi_awready = !state_r.aw_got;
    assign s_axi_wready  = !state_r.w_got;
    assign s_axi_arready = !state_r.rvalid;
    assign s_axi_bvalid  = state_r.bvalid;
    assign s_axi_bresp   = state_r.bresp;
    assign s_axi_rvalid  = state_r.rvalid;
    assign s_axi_rresp   = state_r.rresp;
    assign s_axi_rdata   = {24'h000000, state_r.rdata};
    assign ext_req       = state_r.ext;
    // Level interrupt while an enabled status bit is set
    assign irq           = state_r.done_stat && state_r.done_en;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    // One process carries bus, control and timer behaviour
    always_comb begin
        logic                   do_write;  // Both write halves present
        logic                   done_set;  // Write finished this cycle
        logic [7:0]             wd;        // Written byte
        logic [9:0]             full_addr; // Current EEPROM address
        nac_pkg::nac_space_type new_space; // Space named by a control write
        do_write  = 1'b0;
        done_set  = 1'b0;
        wd        = state_r.w_data;
        full_addr = {state_r.addr_hi, state_r.addr_lo};
        new_space = nac_pkg::NAC_SPACE_EE;
        state_nxt = state_r;
        state_nxt.ext.pulse = 1'b0;

        // Address and data are captured in either order
        if (s_axi_awvalid && !state_r.aw_got) begin
            state_nxt.aw_got  = 1'b1;
            state_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_r.w_got) begin
            state_nxt.w_got   = 1'b1;
            state_nxt.w_data  = s_axi_wdata[7:0];
            state_nxt.w_lane0 = s_axi_wstrb[0];
        end
        if (state_r.bvalid && s_axi_bready) begin
            state_nxt.bvalid = 1'b0;
        end

        // Commit a write once both halves are held and no response waits
        do_write = state_r.aw_got && state_r.w_got && !state_r.bvalid;
        if (do_write) begin
            state_nxt.aw_got = 1'b0;
            state_nxt.w_got  = 1'b0;
            state_nxt.bvalid = 1'b1;
            state_nxt.bresp  = is_mapped(state_r.aw_addr) ? `NAC_RESP_OKAY : `NAC_RESP_SLVERR;
            // any other write spoils the unlock
            state_nxt.unlock = nac_pkg::NAC_LOCKED;
        end

        // Registers hold one byte, so only lane 0 changes them
        if (do_write && state_r.w_lane0) begin
            unique case (state_r.aw_addr)
                `NAC_OFF_CTRL: begin
                    // one control register serves every space
                    state_nxt.permit    = wd[`NAC_CTL_PERMIT];
                    state_nxt.erase_sel = wd[`NAC_CTL_ERASE];
                    state_nxt.cfg_sel   = wd[`NAC_CTL_CFG];
                    state_nxt.pgm_sel   = wd[`NAC_CTL_PGM];
                    new_space = pick_space(wd[`NAC_CTL_CFG], wd[`NAC_CTL_PGM]);
                    // read start only sticks for data EEPROM
                    if (wd[`NAC_CTL_RD] && !state_r.rd_start && state_r.op == nac_pkg::NAC_OP_IDLE
                        && new_space == nac_pkg::NAC_SPACE_EE) begin
                        state_nxt.rd_start = 1'b1;
                    end
                    // a zero written here never clears write start
                    if (wd[`NAC_CTL_WR] && !state_r.wr_start) begin
                        // start needs permit and a fresh unlock
                        if (wd[`NAC_CTL_PERMIT] && state_r.unlock == nac_pkg::NAC_ARMED
                            && !state_r.rd_start) begin
                            state_nxt.wr_start = 1'b1;
                            // fault raised as the write begins
                            state_nxt.fault    = 1'b1;
                            state_nxt.op       = nac_pkg::NAC_OP_WRITE;
                            state_nxt.space    = new_space;
                            state_nxt.count    = 32'h00000000;
                            state_nxt.op_addr  = full_addr;
                            state_nxt.op_data  = state_r.data;
                            state_nxt.op_erase = wd[`NAC_CTL_ERASE];
                            // the EEPROM cell is erased before writing
                            if (new_space == nac_pkg::NAC_SPACE_EE) begin
                                state_nxt.mem[full_addr[IDX_W-1:0]] = `NAC_ERASED_BYTE;
                            end
                        end else begin
                            // an improper attempt leaves the fault visible
                            state_nxt.fault = 1'b1;
                        end
                    end
                end
                `NAC_OFF_UNLOCK: begin
                    if (wd == `NAC_UNLOCK_KEY1) begin
                        state_nxt.unlock = nac_pkg::NAC_HALF;
                    end else if (wd == `NAC_UNLOCK_KEY2 && state_r.unlock == nac_pkg::NAC_HALF) begin
                        // 55h then AAh arms a start
                        state_nxt.unlock = nac_pkg::NAC_ARMED;
                    end else begin
                        state_nxt.unlock = nac_pkg::NAC_LOCKED;
                    end
                end
                `NAC_OFF_DATA:    state_nxt.data    = wd;
                `NAC_OFF_ADDR_LO: state_nxt.addr_lo = wd;
                `NAC_OFF_ADDR_HI: state_nxt.addr_hi = wd[1:0];
                `NAC_OFF_IRQ_CLR: state_nxt.done_stat = state_r.done_stat && !wd[0];
                `NAC_OFF_IRQ_EN:  state_nxt.done_en   = wd[0];
                default: begin
                    // Status is read-only; unmapped writes only drop the unlock
                end
            endcase
        end

        // Read channel: answer taken one cycle after the address
        if (state_r.rvalid && s_axi_rready) begin
            state_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !state_r.rvalid) begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rresp  = is_mapped(s_axi_araddr) ? `NAC_RESP_OKAY : `NAC_RESP_SLVERR;
            unique case (s_axi_araddr)
                `NAC_OFF_CTRL:     state_nxt.rdata = ctrl_image(state_r);
                `NAC_OFF_DATA:     state_nxt.rdata = state_r.data;
                `NAC_OFF_ADDR_LO:  state_nxt.rdata = state_r.addr_lo;
                `NAC_OFF_ADDR_HI:  state_nxt.rdata = {6'h00, state_r.addr_hi};
                `NAC_OFF_IRQ_STAT: state_nxt.rdata = {7'h00, state_r.done_stat};
                `NAC_OFF_IRQ_EN:   state_nxt.rdata = {7'h00, state_r.done_en};
                // unlock port and others read zero
                default:           state_nxt.rdata = 8'h00;
            endcase
        end

        // read start lives one clock, then data is loaded
        if (state_r.rd_start) begin
            state_nxt.data     = state_r.mem[full_addr[IDX_W-1:0]];
            state_nxt.rd_start = 1'b0;
        end

        // Programming timer; the core is expected to wait it out
        if (state_r.op == nac_pkg::NAC_OP_WRITE) begin
            state_nxt.count = state_r.count + 32'h00000001;
            if (state_r.count >= 32'(WRITE_CYCLES - 1)) begin
                state_nxt.op       = nac_pkg::NAC_OP_IDLE;
                state_nxt.wr_start = 1'b0;
                state_nxt.fault    = 1'b0;
                done_set           = 1'b1;
                // program and config selects both low mean the EEPROM array
                if (state_r.space == nac_pkg::NAC_SPACE_EE) begin
                    state_nxt.mem[state_r.op_addr[IDX_W-1:0]] = state_r.op_data;
                end else begin
                    // flash or configuration storage takes the request
                    state_nxt.ext.pulse = 1'b1;
                    state_nxt.ext.erase = state_r.op_erase;
                    state_nxt.ext.space = state_r.space;
                    state_nxt.ext.addr  = state_r.op_addr;
                    state_nxt.ext.data  = state_r.op_data;
                end
            end
        end

        // completion sets the flag; set beats a same-cycle clear
        if (done_set) begin
            state_nxt.done_stat = 1'b1;
        end

        // Reset keeps array contents; a write cut by warm reset leaves the fault up
        if (!aresetn) begin
            state_nxt       = '0;
            state_nxt.mem   = state_r.mem;
            state_nxt.permit = 1'b0;
            // warm reset during a write keeps fault readable
            state_nxt.fault = !cold_start && (state_r.fault || state_r.wr_start);
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Reset is folded into the next-state copy above
    always_ff @(posedge aclk) begin
        state_r <= state_nxt;
    end

endmodule // nac_access_control

`default_nettype wire

// ===== sim/nac_access_control_sva.sv
// Checker for the access control register slave
`timescale 1ns/10ps
`default_nettype none
`include "nac_map.svh"
module nac_access_control_sva (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic [1:0]       s_axi_bresp,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic [7:0]       s_axi_araddr,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic [1:0]       s_axi_rresp,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire nac_pkg::nac_ext_req_type ext_req,
    input wire logic             irq
);
    // ----------------------------------------
    // Steps of a bus transfer
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_unlock_zero;
        s_ar_take ##0 (s_axi_araddr == `NAC_OFF_UNLOCK) |=> s_axi_rvalid && (s_axi_rdata == 32'h0);
    endproperty
    property p_unmapped;
        s_ar_take ##0 (s_axi_araddr > 8'h1C) |=> (s_axi_rresp == `NAC_RESP_SLVERR) && (s_axi_rdata == 32'h0);
    endproperty
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_wr_answer;
        s_wr_take |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_byte_lane;
        s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h0);
    endproperty
    property p_ar_refused;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    property p_pulse_one;
        ext_req.pulse |=> !ext_req.pulse;
    endproperty
    property p_pulse_space;
        ext_req.pulse |-> (ext_req.space != nac_pkg::NAC_SPACE_EE);
    endproperty
    property p_reset_quiet;
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !ext_req.pulse;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read not zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answer wrong");
    a_rhold: assert property (p_rhold) else $error("read answer dropped early");
    a_bhold: assert property (p_bhold) else $error("write answer dropped early");
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    a_byte_lane: assert property (p_byte_lane) else $error("upper read lanes not zero");
    a_ar_refused: assert property (p_ar_refused) else $error("read taken while answer pending");
    a_pulse_one: assert property (p_pulse_one) else $error("store pulse longer than one cycle");
    a_pulse_space: assert property (p_pulse_space) else $error("store pulse for data space");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule // nac_access_control_sva
bind nac_access_control nac_access_control_sva sva_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_req(ext_req), .irq(irq));
`default_nettype wire

// ===== sim/nac_access_control_tb_top.sv
// Register level testbench for the access control block
`timescale 1ns/10ps
`default_nettype none
`include "nac_map.svh"
module nac_access_control_tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        cold_start = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    nac_pkg::nac_ext_req_type ext_req;
    int          miscompares = 0;
    int          comparisons = 0;
    int          n;
    logic [7:0]  v;
    // Short write time keeps the run brief
    nac_access_control #(.WRITE_CYCLES(20)) dut_u (.aclk(aclk), .aresetn(aresetn), .cold_start(cold_start),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_req(ext_req), .irq(irq));
    // ----------------------------------------
    // Clock, compare and bus tasks
    // ----------------------------------------
    always #4 aclk = ~aclk;
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic do_reset(input logic cold);
        @(posedge aclk);
        aresetn <= 1'b0;
        cold_start <= cold;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        cold_start <= 1'b0;
    endtask
    // Handshakes are judged at the falling edge, so the rising edge never races the design
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        bit aw_hs, w_hs, b_hs;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // No cycle count assumed; only the watchdog ends a stuck wait
        while (1'b1) begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) begin
                bready <= 1'b0;
                check_val(bresp, er);
                break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = '1,
                      input logic [1:0] er = 2'h0);
        bit ar_hs, r_hs;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (1'b1) begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs = rvalid;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) begin
                rready <= 1'b0;
                check_val(rdata & m, exp);
                check_val(rresp, er);
                break;
            end
        end
    endtask
    // Unlock pair followed by a start with permit
    task automatic start_write(input logic [7:0] c);
        wr(`NAC_OFF_UNLOCK, 32'h55);
        wr(`NAC_OFF_UNLOCK, 32'hAA);
        wr(`NAC_OFF_CTRL, {24'h0, c});
    endtask
    // ----------------------------------------
    // Watchdog and test sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        print_verdict();
    end
    initial begin
        do_reset(1'b1);
        rd(`NAC_OFF_CTRL, 32'h0);
        rd(`NAC_OFF_UNLOCK, 32'h0);
        rd(8'h20, 32'h0, '1, `NAC_RESP_SLVERR);
        wr(8'h20, 32'h1, `NAC_RESP_SLVERR);
        $display("test reset_map done");
        // Start without unlock or permit must only raise the fault
        wr(`NAC_OFF_CTRL, 32'h02);
        rd(`NAC_OFF_CTRL, 32'h08);
        $display("test bad_start done");
        wr(`NAC_OFF_ADDR_HI, 32'h3);
        wr(`NAC_OFF_ADDR_LO, 32'h5A);
        wr(`NAC_OFF_DATA, 32'hC3);
        wr(`NAC_OFF_IRQ_EN, 32'h1);
        start_write(8'h06);
        rd(`NAC_OFF_CTRL, 32'h0E);
        wr(`NAC_OFF_CTRL, 32'h04);
        rd(`NAC_OFF_CTRL, 32'h0E);
        for (n = 0; n < 100 && irq !== 1'b1; n++) @(negedge aclk);
        check_val(irq, 1'b1);
        rd(`NAC_OFF_CTRL, 32'h04);
        rd(`NAC_OFF_IRQ_STAT, 32'h1);
        wr(`NAC_OFF_IRQ_EN, 32'h0);
        repeat (2) @(negedge aclk);
        check_val(irq, 1'b0);
        wr(`NAC_OFF_IRQ_EN, 32'h1);
        wr(`NAC_OFF_IRQ_CLR, 32'h1);
        repeat (2) @(negedge aclk);
        check_val(irq, 1'b0);
        rd(`NAC_OFF_IRQ_STAT, 32'h0);
        wr(`NAC_OFF_DATA, 32'h0);
        wr(`NAC_OFF_CTRL, 32'h01);
        rd(`NAC_OFF_DATA, 32'hC3);
        rd(`NAC_OFF_CTRL, 32'h0, 32'h1);
        $display("test ee_write done");
        // Read start refused for program and configuration space
        for (n = 0; n < 2; n++) begin
            v = n == 0 ? 8'h81 : 8'h41;
            wr(`NAC_OFF_CTRL, {24'h0, v});
            rd(`NAC_OFF_CTRL, {24'h0, v & 8'hC0}, 32'hC1);
        end
        $display("test read_refused done");
        // Program and configuration stores leave through the request port
        for (n = 0; n < 2; n++) begin
            // Erase variant on the program store so the erase field is seen both ways
            v = n == 0 ? 8'h96 : 8'h46;
            wr(`NAC_OFF_ADDR_LO, 32'h12 + n);
            wr(`NAC_OFF_DATA, 32'h34 + n);
            wr(`NAC_OFF_CTRL, {24'h0, v & 8'hC0});
            start_write(v);
            for (int k = 0; k < 100 && ext_req.pulse !== 1'b1; k++) @(negedge aclk);
            v = {4'h0, 1'b1, n == 0, n == 0 ? nac_pkg::NAC_SPACE_PGM : nac_pkg::NAC_SPACE_CFG};
            check_val({ext_req.pulse, ext_req.erase, ext_req.space}, v);
            check_val({ext_req.addr, ext_req.data}, {2'h3, 8'h12 + n[7:0], 8'h34 + n[7:0]});
            wr(`NAC_OFF_IRQ_CLR, 32'h1);
        end
        $display("test ext_store done");
        // Warm reset in mid write leaves the fault and an erased cell
        wr(`NAC_OFF_ADDR_LO, 32'h5A);
        start_write(8'h06);
        do_reset(1'b0);
        rd(`NAC_OFF_CTRL, 32'h08, 32'h08);
        wr(`NAC_OFF_ADDR_HI, 32'h3);
        wr(`NAC_OFF_ADDR_LO, 32'h5A);
        wr(`NAC_OFF_CTRL, 32'h01);
        rd(`NAC_OFF_DATA, 32'hFF);
        do_reset(1'b1);
        rd(`NAC_OFF_CTRL, 32'h0);
        $display("test reset_cut done");
        print_verdict();
    end
endmodule // nac_access_control_tb_top
`default_nettype wire
